// *** verilog/sbc_pkg.sv ***
`default_nettype none
package sbc_pkg;

  // sizes of the wide variant: 20 address bits, four lanes of eight data bits plus parity
  localparam int ADDR_W     = 20;
  localparam int LANES      = 4;
  localparam int LANE_W     = 9;
  localparam int DATA_W     = LANES * LANE_W;
  localparam int FIFO_DEPTH = 8;
  localparam int BURST_W    = 2;

  // burst position constants
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;

  // synchroniser reset level
  localparam logic SYNC_RST = 1'h0;

  // operating state of the device
  typedef enum logic [1:0] {
    SBC_DESEL,
    SBC_READ,
    SBC_WRITE
  } sbc_state_t;

  // one accepted write, carried through the buffer to the array
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] bit_en;
    logic [DATA_W-1:0] data;
  } sbc_wr_t;

  localparam int WR_W = $bits(sbc_wr_t);

endpackage
`default_nettype wire

// *** verilog/sbc_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;
  logic [PW-1:0]    next_head;

  // honest full and empty from the fill count
  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = clk_en && in_valid && in_ready;
  assign pop       = clk_en && out_valid && out_ready;

  // storage, written only, no reset needed
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // slot that will be the head after this edge
  assign next_head = !pop ? rd_ptr
                   : ((rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1));

  // head word registered for a flop-driven data output
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      out_data <= '0;
    end else if (clk_en) begin
      // a word landing in the head slot bypasses the array, not yet written
      if (push && wr_ptr == next_head) begin
        out_data <= in_data;
      end else begin
        out_data <= mem[next_head];
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/sbc_sram_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbc_sram_ctrl #(
  parameter int ADDR_W     = sbc_pkg::ADDR_W,
  parameter int LANES      = sbc_pkg::LANES,
  parameter int LANE_W     = sbc_pkg::LANE_W,
  parameter int FIFO_DEPTH = sbc_pkg::FIFO_DEPTH
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  input  wire logic                     chip_select_a_n,
  input  wire logic                     chip_select_hi,
  input  wire logic                     chip_select_b_n,
  input  wire logic                     burst_step_sel,
  input  wire logic                     write_n,
  input  wire logic [LANES-1:0]         lane_write_n,
  input  wire logic                     clock_gate_n,
  input  wire logic                     out_enable_n,
  input  wire logic                     burst_order_hi,
  input  wire logic                     sleep_req,
  input  wire logic [ADDR_W-1:0]        addr,
  input  wire logic [LANES*LANE_W-1:0]  dq_in,
  output logic      [LANES*LANE_W-1:0]  dq_out,
  output logic                          dq_oe,
  output logic      [ADDR_W-1:0]        mem_rd_addr,
  output logic                          mem_rd_en,
  input  wire logic [LANES*LANE_W-1:0]  mem_rd_data,
  output logic                          mem_wr_valid,
  input  wire logic                     mem_wr_ready,
  output sbc_pkg::sbc_wr_t              mem_wr,
  output logic                          sleeping
);
  localparam int DATA_W = LANES * LANE_W;
  localparam int BW     = sbc_pkg::BURST_W;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic                     sleep_meta;
  logic                     sleep_s;
  logic                     order_meta;
  logic                     order_s;
  sbc_pkg::sbc_state_t      state;
  sbc_pkg::sbc_state_t      next_state;
  logic [ADDR_W-1:0]        cur_addr;
  logic [ADDR_W-1:0]        next_addr;
  logic [BW-1:0]            start_lo;
  logic [BW-1:0]            next_start_lo;
  logic [BW-1:0]            pos;
  logic [BW-1:0]            next_pos;
  logic                     pend_valid;
  logic                     next_pend_valid;
  logic [ADDR_W-1:0]        pend_addr;
  logic [LANES-1:0]         pend_lanes;
  logic [DATA_W-1:0]        pend_bits;
  logic                     sel_all;
  logic                     lanes_any;
  logic                     edge_live;
  logic                     step;
  logic                     buf_in_ready;
  sbc_pkg::sbc_wr_t         buf_in;
  logic [sbc_pkg::WR_W-1:0] buf_out;

  ////////////////////////////////////////////////////////////////////////////
  // asynchronous static inputs through two flops

  // sleep request synchroniser
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sleep_meta <= sbc_pkg::SYNC_RST;
      sleep_s    <= sbc_pkg::SYNC_RST;
    end else if (clk_en) begin
      sleep_meta <= sleep_req;
      sleep_s    <= sleep_meta;
    end
  end

  // burst order select synchroniser
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      order_meta <= sbc_pkg::SYNC_RST;
      order_s    <= sbc_pkg::SYNC_RST;
    end else if (clk_en) begin
      order_meta <= burst_order_hi;
      order_s    <= order_meta;
    end
  end

  assign sleeping = sleep_s;

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  // all three selects active, lane group active when any lane low
  assign sel_all   = !chip_select_a_n && chip_select_hi && !chip_select_b_n;
  assign lanes_any = !(&lane_write_n);

  // an edge counts unless gated, asleep or frozen
  assign edge_live = clk_en && !clock_gate_n && !sleep_s;
  // a full buffer with a pending write holds the edge as well
  assign step      = edge_live && (!pend_valid || buf_in_ready);

  // next operating state
  always_comb begin
    next_state = state;
    if (burst_step_sel) begin
      next_state = state;
    end else if (!sel_all) begin
      next_state = sbc_pkg::SBC_DESEL;
    end else if (write_n) begin
      next_state = sbc_pkg::SBC_READ;
    end else begin
      next_state = sbc_pkg::SBC_WRITE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // burst address generation

  always_comb begin
    next_start_lo = start_lo;
    next_pos      = pos;
    next_addr     = cur_addr;
    if (!burst_step_sel && sel_all) begin
      next_start_lo = addr[BW-1:0];
      next_pos      = sbc_pkg::BURST_FIRST;
      next_addr     = addr;
    end else if (burst_step_sel && state != sbc_pkg::SBC_DESEL) begin
      next_pos = pos + sbc_pkg::BURST_STEP;
      if (order_s) begin
        next_addr[BW-1:0] = start_lo ^ next_pos;
      end else begin
        next_addr[BW-1:0] = start_lo + next_pos;
      end
    end
  end

  // state, address and burst position move only on a live edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state    <= sbc_pkg::SBC_DESEL;
      cur_addr <= '0;
      start_lo <= sbc_pkg::BURST_FIRST;
      pos      <= sbc_pkg::BURST_FIRST;
    end else if (step) begin
      state    <= next_state;
      cur_addr <= next_addr;
      start_lo <= next_start_lo;
      pos      <= next_pos;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write capture: lanes with the address, data one edge later

  // a write cycle with no lane low is an abort and leaves nothing pending
  assign next_pend_valid = (next_state == sbc_pkg::SBC_WRITE) && lanes_any
                           && (burst_step_sel ? state == sbc_pkg::SBC_WRITE : 1'b1);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pend_valid <= 1'b0;
      pend_addr  <= '0;
      pend_lanes <= '0;
    end else if (step) begin
      pend_valid <= next_pend_valid;
      pend_addr  <= next_addr;
      pend_lanes <= ~lane_write_n;
    end
  end

  // each lane enable covers eight data bits and its parity bit
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign pend_bits[g*LANE_W +: LANE_W] = {LANE_W{pend_lanes[g]}};
    end
  endgenerate

  assign buf_in.addr   = pend_addr;
  assign buf_in.bit_en = pend_bits;
  assign buf_in.data   = dq_in;

  // push only on a live edge, so a gated edge writes nothing
  sbc_fifo #(
    .WIDTH (sbc_pkg::WR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_buf (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .in_valid  (pend_valid && edge_live),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in),
    .out_valid (mem_wr_valid),
    .out_ready (mem_wr_ready),
    .out_data  (buf_out)
  );

  assign mem_wr = sbc_pkg::sbc_wr_t'(buf_out);

  ////////////////////////////////////////////////////////////////////////////
  // read path and bus drive

  // array address from the burst register, read data flows straight through
  assign mem_rd_addr = cur_addr;
  assign mem_rd_en   = (state == sbc_pkg::SBC_READ);
  assign dq_out      = mem_rd_data;

  // drive only in a read, while output enable is low and awake
  assign dq_oe = (state == sbc_pkg::SBC_READ) && !out_enable_n && !sleep_s;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // all checks on the system clock, off during reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // a gated edge leaves state, address and position alone
  stall_hold_a: assert property ($past(clk_en && clock_gate_n) && $past(rst_n)
    |-> $stable(state) && $stable(cur_addr) && $stable(pos))
    else $error("state moved on a gated edge");

  // a load with a select inactive deselects and floats the bus
  desel_cmd_a: assert property (step && !burst_step_sel && !sel_all
    |=> state == sbc_pkg::SBC_DESEL ##0 !dq_oe)
    else $error("deselect command not taken");

  // read begin loads the external address
  read_load_a: assert property (step && !burst_step_sel && sel_all && write_n
    |=> state == sbc_pkg::SBC_READ && cur_addr == $past(addr) && mem_rd_en)
    else $error("read begin did not load address");

  // write begin loads the address, pending only with a lane low
  write_load_a: assert property (step && !burst_step_sel && sel_all && !write_n
    |=> state == sbc_pkg::SBC_WRITE && cur_addr == $past(addr)
        && pend_valid == $past(lanes_any))
    else $error("write begin did not load address");

  // a continue keeps the operation whatever the selects say
  continue_op_a: assert property (step && burst_step_sel
    |=> state == $past(state))
    else $error("continue changed operation");

  // interleaved step inverts the low bits by position
  interleave_a: assert property (step && burst_step_sel && order_s
    && state != sbc_pkg::SBC_DESEL
    |=> cur_addr[BW-1:0] == ($past(start_lo) ^ $past(pos + sbc_pkg::BURST_STEP))
        && cur_addr[ADDR_W-1:BW] == $past(cur_addr[ADDR_W-1:BW]))
    else $error("interleaved step wrong");

  // linear step counts the low bits, upper bits fixed
  linear_a: assert property (step && burst_step_sel && !order_s
    && state != sbc_pkg::SBC_DESEL
    |=> cur_addr[BW-1:0] == $past(start_lo + pos + sbc_pkg::BURST_STEP)
        && cur_addr[ADDR_W-1:BW] == $past(cur_addr[ADDR_W-1:BW]))
    else $error("linear step wrong");

  // bus driven only in a read with output enable low
  no_drive_a: assert property (state != sbc_pkg::SBC_READ || out_enable_n |-> !dq_oe)
    else $error("bus driven outside a read");

  // a write cycle with every lane high leaves nothing pending
  abort_nowrite_a: assert property (step && next_state == sbc_pkg::SBC_WRITE
    && !lanes_any |=> !pend_valid)
    else $error("abort left a write pending");

  // a gated edge never adds a word to the write buffer
  gated_nowrite_a: assert property (!edge_live
    |=> u_wr_buf.count <= $past(u_wr_buf.count))
    else $error("write pushed on a gated edge");

  // state and address never move while asleep
  sleep_hold_a: assert property (sleep_s ##1 sleep_s
    |-> $stable(state) && $stable(cur_addr))
    else $error("state moved while asleep");

  // a continue from deselect stays deselected
  desel_hold_a: assert property (step && burst_step_sel && state == sbc_pkg::SBC_DESEL
    |=> state == sbc_pkg::SBC_DESEL && !mem_rd_en)
    else $error("continue left deselect");

  // a read continue keeps reading in the same block of four
  read_step_a: assert property (step && burst_step_sel && state == sbc_pkg::SBC_READ
    |=> mem_rd_en && cur_addr[ADDR_W-1:BW] == $past(cur_addr[ADDR_W-1:BW]))
    else $error("read continue lost the read");

  // a write continue with a lane low leaves a write pending at the new address
  write_step_a: assert property (step && burst_step_sel && state == sbc_pkg::SBC_WRITE
    && lanes_any |=> pend_valid && pend_addr == cur_addr)
    else $error("write continue not pending");

  // the first and last lane enables each cover one whole lane
  lane_bits_a: assert property (step
    |=> pend_bits[LANE_W-1:0] == {LANE_W{!$past(lane_write_n[0])}}
        && pend_bits[DATA_W-1 -: LANE_W] == {LANE_W{!$past(lane_write_n[LANES-1])}})
    else $error("lane enable mapped to wrong bits");

  // the pending write holds over a dead edge
  stall_pend_a: assert property (!step
    |=> $stable(pend_valid) && $stable(pend_addr) && $stable(pend_lanes))
    else $error("pending write moved on a dead edge");

  // a dead edge in a read keeps the bus driven
  stall_drive_a: assert property (state == sbc_pkg::SBC_READ && !edge_live && !sleep_s
    ##1 !out_enable_n && !sleep_s
    |-> dq_oe)
    else $error("bus released on a dead read edge");

  // a full buffer holds the whole edge so no write is lost
  full_hold_a: assert property (pend_valid && edge_live && !buf_in_ready
    |=> $stable(state) && $stable(cur_addr) && pend_valid)
    else $error("write lost at a full buffer");

  // main scenarios
  read_burst_c: cover property ((step && state == sbc_pkg::SBC_READ && burst_step_sel) [*3]);
  write_burst_c: cover property (mem_wr_valid && !mem_wr_ready ##1 !buf_in_ready);
  stall_read_c: cover property (state == sbc_pkg::SBC_READ && clock_gate_n && dq_oe);
  write_abort_c: cover property (step && state == sbc_pkg::SBC_WRITE
    && burst_step_sel && !lanes_any);
endmodule
`default_nettype wire

// *** tb/sbc_array_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbc_array_model (
  input  wire logic             sys_clk,
  input  wire logic [19:0]      rd_addr,
  input  wire logic             rd_en,
  output logic      [35:0]      rd_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire sbc_pkg::sbc_wr_t wr,
  input  wire logic             stall
);
  sbc_pkg::sbc_wr_t got[$];
  logic             tgl = 1'h0;

  ////////////////////////////////////////////////////////////
  // read side: address pattern, toggling junk when not read
  always_comb begin
    rd_data = rd_en ? ({16'h0, rd_addr} ^ 36'h5a0000000) : {36{tgl}};
  end

  // write side: stalls on request, logs every accepted word
  assign wr_ready = ~stall;
  always @(posedge sys_clk) begin
    tgl <= ~tgl;
    if (wr_valid && wr_ready) begin
      got.push_back(wr);
    end
  end
endmodule
`default_nettype wire

// *** tb/sbc_sram_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbc_sram_ctrl_test;
  localparam logic [2:0] GOOD = 3'h2;
  logic             sys_clk = 1'h0;
  logic             rst_n = 1'h0;
  logic             clk_en = 1'h1;
  logic [2:0]       sel = 3'h5;
  logic             step = 1'h0;
  logic             write_n = 1'h1;
  logic [3:0]       lanes = 4'hf;
  logic             gate = 1'h0;
  logic             oe_n = 1'h0;
  logic             order = 1'h1;
  logic             sleep_req = 1'h0;
  logic             stall = 1'h0;
  logic [19:0]      addr = 20'h0;
  logic [35:0]      dq_in = 36'h0;
  logic [35:0]      dq_out;
  logic [35:0]      rd_data;
  logic [19:0]      rd_addr;
  logic             dq_oe;
  logic             rd_en;
  logic             wr_valid;
  logic             wr_ready;
  logic             sleeping;
  sbc_pkg::sbc_wr_t wr;
  int               error_cnt = 0;
  int               n_compared = 0;

  always #10 sys_clk = ~sys_clk;

  sbc_sram_ctrl dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .chip_select_a_n(sel[2]),
    .chip_select_hi(sel[1]), .chip_select_b_n(sel[0]), .burst_step_sel(step),
    .write_n(write_n), .lane_write_n(lanes), .clock_gate_n(gate), .out_enable_n(oe_n),
    .burst_order_hi(order), .sleep_req(sleep_req), .addr(addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .mem_rd_addr(rd_addr), .mem_rd_en(rd_en),
    .mem_rd_data(rd_data), .mem_wr_valid(wr_valid), .mem_wr_ready(wr_ready),
    .mem_wr(wr), .sleeping(sleeping)
  );
  sbc_array_model model (
    .sys_clk(sys_clk), .rd_addr(rd_addr), .rd_en(rd_en), .rd_data(rd_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr(wr), .stall(stall)
  );

  ////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [35:0] pat(input logic [19:0] a);
    pat = {16'h0, a} ^ 36'h5a0000000;
  endfunction
  function automatic logic [35:0] dat(input int k);
    dat = 36'h9abcdef01 + 36'(k) * 36'h111111111;
  endfunction
  function automatic logic [35:0] lane_mask(input logic [3:0] l);
    for (int k = 0; k < 4; k++) begin
      lane_mask[9*k +: 9] = {9{~l[k]}};
    end
  endfunction
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick();
    @(negedge sys_clk);
  endtask
  task automatic drv(input logic s, input logic w, input logic [3:0] l,
                     input logic [19:0] a, input logic [2:0] cs);
    step = s;
    write_n = w;
    lanes = l;
    addr = a;
    sel = cs;
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic reset(input logic o);
    tick();
    rst_n = 1'h0;
    order = o; // order select only changes under reset
    drv(1'h0, 1'h1, 4'hf, 20'h0, 3'h5);
    repeat (12) tick();
    chk("rst_rd_en", 36'h0, 36'(rd_en));
    chk("rst_wr_valid", 36'h0, 36'(wr_valid));
    rst_n = 1'h1;
    repeat (3) tick();
  endtask
  task automatic rd_burst(input logic [19:0] a);
    logic [19:0] e;
    drv(1'h0, 1'h1, 4'hf, a, GOOD);
    for (int k = 0; k < 4; k++) begin
      tick();
      e = order ? a ^ 20'(k) : {a[19:2], 2'(a[1:0] + 2'(k))};
      chk("rd_addr", 36'(e), 36'(rd_addr));
      chk("rd_data", pat(e), dq_out);
      chk("rd_oe", 36'h1, 36'(dq_oe));
      if (k < 3) begin
        drv(1'h1, 1'h0, 4'h0, 20'h0, 3'h5); // selects, strobe, lanes ignored
      end
    end
  endtask
  task automatic oe_stall();
    drv(1'h0, 1'h1, 4'hf, 20'h00ab1, GOOD);
    tick();
    oe_n = 1'h1;
    #1;
    chk("oe_off", 36'h0, 36'(dq_oe));
    oe_n = 1'h0;
    drv(1'h1, 1'h1, 4'hf, 20'h0, GOOD);
    gate = 1'h1;
    repeat (2) begin
      tick();
      chk("stall_addr", 36'h00ab1, 36'(rd_addr));
      chk("stall_oe", 36'h1, 36'(dq_oe));
    end
    gate = 1'h0;
    tick();
    chk("stall_next", 36'h00ab0, 36'(rd_addr));
    clk_en = 1'h0;
    repeat (2) tick();
    chk("frz_addr", 36'h00ab0, 36'(rd_addr));
    clk_en = 1'h1;
    tick();
    chk("frz_next", 36'h00ab3, 36'(rd_addr));
  endtask
  task automatic desel();
    logic [2:0] bad[3] = '{3'h6, 3'h0, 3'h3};
    foreach (bad[i]) begin
      drv(1'h0, 1'h1, 4'hf, 20'h00100, GOOD);
      tick();
      drv(1'h0, 1'h1, 4'hf, 20'h00200, bad[i]);
      tick();
      chk("ds_oe", 36'h0, 36'(dq_oe));
      drv(1'h1, 1'h1, 4'hf, 20'h0, GOOD);
      tick();
      chk("ds_hold", 36'h0, 36'(rd_en));
    end
  endtask
  task automatic wr_burst();
    logic [3:0]       ln[6] = '{4'h0, 4'he, 4'hd, 4'hb, 4'hf, 4'h7};
    int               idx[5] = '{0, 1, 2, 3, 5};
    sbc_pkg::sbc_wr_t w;
    stall = 1'h1;
    drv(1'h0, 1'h0, ln[0], 20'h01236, GOOD);
    for (int k = 1; k <= 6; k++) begin
      tick();
      chk("wr_oe", 36'h0, 36'(dq_oe));
      dq_in = dat(k - 1);
      if (k < 6) begin
        drv(1'h1, 1'h1, ln[k], 20'h0, 3'h5); // strobe ignored
      end else begin
        drv(1'h0, 1'h1, 4'hf, 20'h0, 3'h5);
      end
      if (k == 3) begin
        gate = 1'h1;
        tick();
        chk("gate_oe", 36'h0, 36'(dq_oe));
        gate = 1'h0;
      end
    end
    tick();
    stall = 1'h0;
    for (int n = 0; n < 40 && model.got.size() < 5; n++) tick();
    chk("wr_count", 36'h5, 36'(model.got.size()));
    foreach (idx[j]) begin
      w = model.got.pop_front();
      chk("wr_addr", 36'(20'h01236 ^ 20'(idx[j] % 4)), 36'(w.addr));
      chk("wr_en", lane_mask(ln[idx[j]]), w.bit_en);
      chk("wr_data", dat(idx[j]) & w.bit_en, w.data & w.bit_en);
    end
  endtask
  task automatic sleep_chk();
    drv(1'h0, 1'h1, 4'hf, 20'h00cd2, GOOD);
    tick();
    drv(1'h1, 1'h1, 4'hf, 20'h0, GOOD);
    gate = 1'h1;
    sleep_req = 1'h1;
    repeat (5) tick();
    gate = 1'h0;
    chk("sleep_on", 36'h1, 36'(sleeping));
    repeat (3) tick();
    chk("sleep_addr", 36'h00cd2, 36'(rd_addr));
    gate = 1'h1;
    sleep_req = 1'h0;
    repeat (5) tick();
    chk("wake", 36'h0, 36'(sleeping));
    chk("wake_oe", 36'h1, 36'(dq_oe));
    gate = 1'h0;
    tick();
    chk("wake_addr", 36'h00cd3, 36'(rd_addr));
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    reset(1'h1);
    rd_burst(20'h5a3c1);
    oe_stall();
    desel();
    wr_burst();
    sleep_chk();
    reset(1'h0);
    rd_burst(20'h5a3c1);
    give_verdict();
  end
  initial begin
    #(20 * 4000);
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
